// ---- design/afp_params.svh ----
`ifndef AFP_PARAMS_SVH
`define AFP_PARAMS_SVH
// register byte offsets
`define AFP_OFS_MODE        4'h0
`define AFP_OFS_STATUS      4'h4
`define AFP_OFS_DATA        4'h8
// mode register field positions
`define AFP_MODE_AVG_LO     16
`define AFP_MODE_AVG_HI     17
`define AFP_MODE_STA_APP    20
`define AFP_MODE_FILT_ORD   15
`define AFP_MODE_RSVD       14
`define AFP_MODE_PAR_EN     13
// status register field positions
`define AFP_STA_RDY         0
`define AFP_STA_SETTLED     1
`define AFP_STA_PARITY      2
`define AFP_STA_RSVD_ERR    3
`define AFP_STA_THIRD       4
// reset values and settling counts
`define AFP_MODE_RESET      32'h0000_0000
`define AFP_SETTLE_THIRD    3'h3
`define AFP_SETTLE_FOURTH   3'h4
// averaging ratios
`define AFP_AVG_NONE        5'h01
`define AFP_AVG_BY2         5'h02
`define AFP_AVG_BY8         5'h08
`define AFP_AVG_BY16        5'h10
`endif

// ---- design/afp_pkg.sv ----
package afp_pkg;
	typedef struct packed {
		logic       status_append_enable;
		logic       averaging_factor_hi;
		logic       averaging_factor_lo;
		logic       filter_order_select;
		logic       reserved_bit;
		logic       parity_check_enable;
	} afp_mode_t;

	typedef struct packed {
		logic [4:0] avg_ratio;
		logic       fast_settle;
		logic       third_order;
	} afp_filt_cfg_t;
endpackage : afp_pkg

// ---- design/afp_mode_ctrl.sv ----
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "afp_params.svh"
// Contract
// - filter order bit clear selects fourth order (reset), set selects third order
// - chop off: settle in three periods for third order, four for fourth
// - parity enable set gives parity checking on conversion data reads when status append is also set
// - status append set sends status with the result on every data read
// - averaging field: 00 none and no fast settling, 01 by 2, 10 by 8, 11 by 16
module afp_mode_ctrl #(
	parameter int DATA_W = 24
) (
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic                   conv_tick,
	input  wire logic                   conv_restart,
	input  wire logic [DATA_W-1:0]      conv_data,
	input  wire logic                   conv_valid,
	output afp_pkg::afp_filt_cfg_t      filt_cfg,
	output logic                        settled
);
	import afp_pkg::*;

	// refuse a width or a field map that the logic cannot serve
	generate
		if (DATA_W < 1 || DATA_W > 24) begin : g_bad_width
			$error("DATA_W must be 1 to 24 so status fits above the result");
		end
		if (`AFP_MODE_STA_APP > 31 || `AFP_MODE_AVG_HI > 31 || `AFP_MODE_AVG_LO > 31) begin : g_bad_mode_a
			$error("mode field positions must lie inside the 32-bit word");
		end
		if (`AFP_MODE_FILT_ORD > 31 || `AFP_MODE_RSVD > 31 || `AFP_MODE_PAR_EN > 31) begin : g_bad_mode_b
			$error("mode field positions must lie inside the 32-bit word");
		end
		if (`AFP_STA_RDY > 7 || `AFP_STA_SETTLED > 7 || `AFP_STA_PARITY > 7) begin : g_bad_status_a
			$error("status field positions must lie inside the appended byte");
		end
		if (`AFP_STA_RSVD_ERR > 7 || `AFP_STA_THIRD > 7) begin : g_bad_status_b
			$error("status field positions must lie inside the appended byte");
		end
		if (`AFP_SETTLE_THIRD == 3'h0 || `AFP_SETTLE_FOURTH == 3'h0) begin : g_bad_settle
			$error("settling counts must be at least one output period");
		end
	endgenerate

	// unpack a 32-bit mode word into the stored fields
	function automatic afp_mode_t mode_from_word(input logic [31:0] w);
		afp_mode_t m;
		m.status_append_enable = w[`AFP_MODE_STA_APP];
		m.averaging_factor_hi  = w[`AFP_MODE_AVG_HI];
		m.averaging_factor_lo  = w[`AFP_MODE_AVG_LO];
		m.filter_order_select  = w[`AFP_MODE_FILT_ORD];
		m.reserved_bit         = w[`AFP_MODE_RSVD];
		m.parity_check_enable  = w[`AFP_MODE_PAR_EN];
		return m;
	endfunction : mode_from_word

	// averaging field to decimation ratio
	function automatic logic [4:0] cfg_ratio(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'b00: cfg_ratio = `AFP_AVG_NONE;
			2'b01: cfg_ratio = `AFP_AVG_BY2;
			2'b10: cfg_ratio = `AFP_AVG_BY8;
			2'b11: cfg_ratio = `AFP_AVG_BY16;
		endcase
	endfunction : cfg_ratio

	afp_mode_t          mode_r;
	afp_mode_t          mode_nxt;
	logic               wait_r;
	logic               wait_nxt;
	logic [31:0]        rdata_r;
	logic [31:0]        rdata_nxt;
	logic [DATA_W-1:0]  data_r;
	logic [DATA_W-1:0]  data_nxt;
	logic               rdy_r;
	logic               rdy_nxt;
	logic [2:0]         cnt_r;
	logic [2:0]         cnt_nxt;
	logic               settled_r;
	logic               settled_nxt;
	afp_filt_cfg_t      cfg_r;
	afp_filt_cfg_t      cfg_nxt;
	logic [31:0]        mode_word;
	logic [31:0]        status_word;
	logic [31:0]        data_word;

	// register bus decode
	wire        req          = avs_read | avs_write;
	wire        accept       = req & wait_r;
	wire        done         = req & ~wait_r;
	wire        sel_mode     = avs_address == `AFP_OFS_MODE;
	wire        sel_status   = avs_address == `AFP_OFS_STATUS;
	wire        sel_data     = avs_address == `AFP_OFS_DATA;
	wire        wr_mode      = done & avs_write & sel_mode;
	wire        rd_data      = done & avs_read & sel_data;
	wire        cap_read     = accept & avs_read;

	// settling count and filter setup
	wire        restart      = wr_mode | conv_restart;
	wire [2:0]  settle_tgt   = mode_r.filter_order_select ? `AFP_SETTLE_THIRD : `AFP_SETTLE_FOURTH;
	wire        cnt_full     = cnt_r >= settle_tgt;
	wire        cnt_step     = conv_tick & ~cnt_full;
	wire        par_bit      = mode_r.parity_check_enable & (^data_r);
	wire [4:0]  avg_ratio_nxt = cfg_ratio(mode_r.averaging_factor_hi, mode_r.averaging_factor_lo);
	wire        fast_nxt      = mode_r.averaging_factor_hi | mode_r.averaging_factor_lo;

	// read words
	always_comb begin
		mode_word                        = 32'h0;
		mode_word[`AFP_MODE_STA_APP]     = mode_r.status_append_enable;
		mode_word[`AFP_MODE_AVG_HI]      = mode_r.averaging_factor_hi;
		mode_word[`AFP_MODE_AVG_LO]      = mode_r.averaging_factor_lo;
		mode_word[`AFP_MODE_FILT_ORD]    = mode_r.filter_order_select;
		mode_word[`AFP_MODE_RSVD]        = mode_r.reserved_bit;
		mode_word[`AFP_MODE_PAR_EN]      = mode_r.parity_check_enable;
	end

	always_comb begin
		status_word                      = 32'h0;
		status_word[`AFP_STA_RDY]        = rdy_r;
		status_word[`AFP_STA_SETTLED]    = settled_r;
		status_word[`AFP_STA_PARITY]     = par_bit;
		status_word[`AFP_STA_RSVD_ERR]   = mode_r.reserved_bit;
		status_word[`AFP_STA_THIRD]      = mode_r.filter_order_select;
	end

	// status byte rides in the top byte only when appended
	wire [7:0]  sta_byte     = mode_r.status_append_enable ? status_word[7:0] : 8'h00;
	wire [23:0] res_word     = 24'(data_r);
	assign data_word = {sta_byte, res_word};
	wire [31:0] rd_mux = sel_mode ? mode_word : sel_status ? status_word : sel_data ? data_word : 32'h0;

	// next values; a new result wins over a clearing read
	assign mode_nxt    = wr_mode ? mode_from_word(avs_writedata) : mode_r;
	assign wait_nxt    = ~accept;
	assign rdata_nxt   = cap_read ? rd_mux : rdata_r;
	assign data_nxt    = conv_valid ? conv_data : data_r;
	assign rdy_nxt     = conv_valid | (rdy_r & ~rd_data);
	assign cnt_nxt     = restart ? 3'h0 : cnt_step ? cnt_r + 3'h1 : cnt_r;
	assign settled_nxt = ~restart & cnt_full;
	assign cfg_nxt     = '{avg_ratio: avg_ratio_nxt, fast_settle: fast_nxt, third_order: mode_r.filter_order_select};

	// bus handshake: one wait cycle, then the request completes
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= wait_nxt;
		end
	end

	// read data captured when the request is first seen
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_r <= 32'h0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// mode fields
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mode_r <= mode_from_word(`AFP_MODE_RESET);
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// result capture
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			data_r <= '0;
		end else begin
			data_r <= data_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdy_r <= 1'b0;
		end else begin
			rdy_r <= rdy_nxt;
		end
	end

	// settling counter in output periods
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			settled_r <= 1'b0;
		end else begin
			settled_r <= settled_nxt;
		end
	end

	// filter setup follows the mode fields one cycle later
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cfg_r <= '{avg_ratio: `AFP_AVG_NONE, fast_settle: 1'b0, third_order: 1'b0};
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign filt_cfg        = cfg_r;
	assign settled         = settled_r;
endmodule : afp_mode_ctrl

// ---- testbench/afp_mode_ctrl_properties.sv ----
`timescale 1ns/1ps
module afp_mode_ctrl_properties (
	input wire logic                   core_clk,
	input wire logic                   nrst,
	input wire logic [3:0]             avs_address,
	input wire logic                   avs_read,
	input wire logic                   avs_write,
	input wire logic [31:0]            avs_writedata,
	input wire logic [31:0]            avs_readdata,
	input wire logic                   avs_waitrequest,
	input wire logic                   conv_tick,
	input wire logic                   conv_restart,
	input wire afp_pkg::afp_filt_cfg_t filt_cfg,
	input wire logic                   settled
);
	import afp_pkg::*;
	logic [31:0] m_r;
	logic [2:0]  c_r;
	wire         wr0 = avs_write && !avs_waitrequest && avs_address == 4'h0;
	wire         rd8 = avs_read && !avs_waitrequest && avs_address == 4'h8;
	wire [2:0]   tgt = filt_cfg.third_order ? 3'h3 : 3'h4;
	always_ff @(posedge core_clk) begin
		m_r <= !nrst ? 32'h0 : wr0 ? avs_writedata : m_r;
		c_r <= (!nrst || wr0 || conv_restart) ? 3'h0 : c_r + {2'h0, conv_tick && c_r != 3'h7};
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence mw_s; wr0 ##2 1'b1; endsequence
	order_follow_a: assert property (mw_s |-> filt_cfg.third_order == m_r[15]) else $error("order");
	avg_ratio_a: assert property (mw_s |-> filt_cfg.avg_ratio == (m_r[17] ? (m_r[16] ? 5'h10 : 5'h08)
		: (m_r[16] ? 5'h02 : 5'h01)) && filt_cfg.fast_settle == (m_r[17] | m_r[16])) else $error("avg");
	settle_early_a: assert property ($rose(settled) |-> c_r >= tgt) else $error("early");
	settle_reach_a: assert property ((c_r >= tgt) [*2] |-> settled) else $error("late");
	parity_bit_a: assert property (rd8 && m_r[20] && m_r[13] |-> avs_readdata[26] == ^avs_readdata[23:0])
		else $error("parity");
	append_off_a: assert property (rd8 && !m_r[20] |-> avs_readdata[31:24] == 8'h00) else $error("append");
endmodule : afp_mode_ctrl_properties

// ---- testbench/afp_conv_src.sv ----
`timescale 1ns/1ps
module afp_conv_src (
	input  wire logic        core_clk,
	input  wire logic        run,
	input  wire logic [23:0] value,
	output logic             conv_tick = 1'b0,
	output logic             conv_valid = 1'b0,
	output logic [23:0]      conv_data = 24'h0
);
	logic [2:0] d_r = 3'h0;
	always @(posedge core_clk) begin
		d_r <= d_r + 3'h1;
		conv_tick <= run && d_r == 3'h7;
		conv_valid <= run && d_r == 3'h7;
		conv_data <= (run && d_r == 3'h7) ? value : ~value;
	end
endmodule : afp_conv_src

// ---- testbench/test_afp_mode_ctrl.sv ----
`timescale 1ns/1ps
module test_afp_mode_ctrl;
	import afp_pkg::*;
	logic core_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, conv_restart = 1'b0, run = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, conv_tick, conv_valid, settled;
	logic [23:0] conv_data, value = 24'h000007;
	afp_filt_cfg_t filt_cfg;
	int n_fail = 0, n_compared = 0;
	always #10 core_clk = ~core_clk;
	afp_mode_ctrl afp_mode_ctrl_inst (.*);
	afp_conv_src afp_conv_src_inst (.*);
	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask : chk
	task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : acc
	task automatic settle(input logic t, input int n);
		run <= 1'b0;
		acc(1'b1, 4'h0, {16'h0, t, 15'h0});
		run <= 1'b1;
		for (int k = 1; k <= 5; k++) begin
			@(posedge conv_tick);
			repeat (3) @(posedge core_clk);
			chk("settled", settled, k >= n);
		end
	endtask : settle
	task automatic final_report;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		chk("cfg", filt_cfg, {5'h01, 2'b00});
		for (int m = 0; m < 8; m++) begin
			acc(1'b1, 4'h0, {14'h0, m[1:0], m[2], 15'h0});
			repeat (2) @(posedge core_clk);
			chk("avg", filt_cfg, {m[1] ? (m[0] ? 5'h10 : 5'h08) : (m[0] ? 5'h02 : 5'h01), |m[1:0], m[2]});
		end
		$display("test cfg done");
		settle(1'b1, 3);
		settle(1'b0, 4);
		conv_restart <= 1'b1;
		@(posedge core_clk);
		conv_restart <= 1'b0;
		@(posedge core_clk);
		chk("restart", settled, 1'b0);
		$display("test settle done");
		acc(1'b1, 4'h0, 32'h0010_2000);
		repeat (10) @(posedge core_clk);
		acc(1'b0, 4'h8, 32'h0);
		chk("data", q, 32'h0500_0007);
		run <= 1'b0;
		acc(1'b1, 4'h0, 32'h0000_8000);
		acc(1'b0, 4'h8, 32'h0);
		chk("noapp", q, 32'h0000_0007);
		acc(1'b0, 4'h4, 32'h0);
		chk("status", q, 32'h0000_0010);
		acc(1'b0, 4'hc, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test read done");
		final_report;
	end
	initial begin
		#100000;
		n_fail++;
		final_report;
	end
endmodule : test_afp_mode_ctrl
bind afp_mode_ctrl afp_mode_ctrl_properties afp_mode_ctrl_properties_inst (.*);
